// ===== hdl/pmc_cfg.svh
// Purpose: constants of the power-mode controller (offsets, fields, resets, timing)
// Assumes: 50 MHz ref_clk
// Notes: counts are derived from times in their own units
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// control register location and power-up value
`define PMC_CTRL_ADDR 8'h60
`define PMC_CTRL_RESET 8'h00

// control register field positions
`define PMC_BIT_NEG_BLANK 7
`define PMC_BIT_LOW_CELL 6
`define PMC_BIT_BUS_LOW 5
`define PMC_BIT_NET_OP 4
`define PMC_BIT_RSVD 3
`define PMC_BIT_PIN_PSW 2
`define PMC_BIT_LINE_PSW 1

// read-net-address opcode choices
`define PMC_NET_OP_SEL0 8'h33
`define PMC_NET_OP_SEL1 8'h39

// clock rate and times
`define PMC_CLK_KHZ 50000
`define PMC_SLEEP_TIMEOUT_MS 2000
`define PMC_DEBOUNCE_MS 100
`define PMC_SLEEP_CYCLES (`PMC_SLEEP_TIMEOUT_MS * `PMC_CLK_KHZ)
`define PMC_DEBOUNCE_CYCLES (`PMC_DEBOUNCE_MS * `PMC_CLK_KHZ)

`endif

// ===== hdl/pmc_pkg.sv
// Purpose: types shared by the power-mode controller
// Assumes: nothing
// Notes: constants live in pmc_cfg.svh
package pmc_pkg;

  // power modes
  typedef enum logic {PMC_ACTIVE, PMC_SLEEP} pmc_mode_type;

  // register access from the serial protocol engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_reg_req_type;

  // protection monitor verdicts per gate driver
  typedef struct packed {
    logic charge;
    logic discharge;
  } pmc_fet_type;

endpackage

// ===== hdl/pmc_stable_timer.sv
// Purpose: counts cycles a level has held still, restarting on each change
// Assumes: level is already synchronised to ref_clk
// Notes: stable is high once level has held COUNT cycles, until it changes
`timescale 1ns/10ps
`default_nettype none

module pmc_stable_timer #(
  parameter int COUNT = 16,
  parameter int W = $clog2(COUNT + 1)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic clear,
  output logic stable
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic level_q;
  logic next_level_q;
  logic held;
  logic next_held;

  // restart on a change or clear, saturate at the target
  always_comb
  begin
    next_level_q = level;
    next_count = count;
    if (clear || (level != level_q))
      next_count = '0;
    else if (count != W'(COUNT))
      next_count = count + W'(1);
    next_held = (next_count == W'(COUNT)) && !clear;
  end

  // held trails level by a cycle, so a fresh change must veto it at once
  assign stable = held && (level == level_q) && !clear;

  // register state
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
      level_q <= 1'b0;
      held <= 1'b0;
    end
    else
    begin
      count <= next_count;
      level_q <= next_level_q;
      held <= next_held;
    end
  end

endmodule // pmc_stable_timer

`default_nettype wire

// ===== hdl/pmc_power_mode.sv
// Purpose: Active/Sleep power-mode controller with control register
// Assumes: register requests, recall and copy strobes come from the serial engine
// Notes: data line and programmable pin are asynchronous and synchronised here
//
// Behaviour
// - start in Active after power-up
// - gate drivers on only when monitor says safe
// - Sleep halts measurement, drivers off, registers kept
// - hash requests refused while asleep
// - no Sleep while charger or charge current
// - bus-low enable plus line low timeout sleeps
// - undervoltage enable, low cell, static line sleeps
// - undervoltage never sleeps when its enable clear
// - wake on charger with good cell, line rise unless line power switch on
// - undervoltage sleep wakes on any line change unless line power switch on
// - power switch: weak pullup, then arm falling
// - debounce power-switch wake for 100 ms
// - pin and line power switches act independently
// - control register read/write, recalled, saved by copy
// - bit 7 enables negative current blanking
// - opcode select picks 33h or 39h
`include "pmc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pmc_power_mode #(
  parameter int SLEEP_CYCLES = `PMC_SLEEP_CYCLES,
  parameter int DEBOUNCE_CYCLES = `PMC_DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe,
  input wire logic programmable_pin_in,
  output logic programmable_pin_out,
  output logic programmable_pin_oe,
  input wire logic charger_detect,
  input wire logic charge_current_detect,
  input wire logic cell_below_uv,
  input wire pmc_pkg::pmc_fet_type protect_ok,
  input wire logic hash_req,
  input wire pmc_pkg::pmc_reg_req_type reg_req,
  input wire logic ee_recall_valid,
  input wire logic [7:0] ee_recall_data,
  input wire logic copy_data_cmd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic ee_save_strobe,
  output logic [7:0] ee_save_data,
  output logic mode_active,
  output logic measure_en,
  output logic charge_fet_drive,
  output logic discharge_fet_drive,
  output logic hash_start,
  output logic hash_reject,
  output logic neg_current_blank_en,
  output logic [7:0] net_addr_opcode
);

  // synchronisers: [0] line, [1] pin
  logic [1:0] sync1, sync2;
  logic [1:0] next_sync1, next_sync2;
  logic dq_q, next_dq_q;

  // mode state
  pmc_pkg::pmc_mode_type mode, next_mode;
  logic uv_sleep, next_uv_sleep;
  logic [1:0] armed, next_armed;
  logic [1:0] psw_en, psw_stable;

  // control register
  logic [7:0] ctrl, next_ctrl;

  // registered outputs
  logic [7:0] next_reg_rdata, next_ee_save_data;
  logic next_reg_rvalid, next_ee_save_strobe, next_mode_active;
  logic next_charge, next_discharge, next_hash_start, next_hash_reject;
  logic [1:0] next_pull_oe, pull_oe;

  // derived conditions
  logic dq_s, dq_rise, dq_change, dq_static;
  logic sleep_block, bus_low_go, uv_go, psw_wake, line_wake;

  // decode of the one mapped register, used by write and read paths
  function automatic logic ctrl_hit(input logic [7:0] addr);
    ctrl_hit = (addr == `PMC_CTRL_ADDR);
  endfunction

  // two-flop synchronisers; dq_q is a third stage for edge detection
  always_comb
  begin
    next_sync1 = {programmable_pin_in, data_line_in};
    next_sync2 = sync1;
    next_dq_q = sync2[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      dq_q <= 1'b1;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      dq_q <= next_dq_q;
    end
  end

  assign dq_s = sync2[0];
  assign dq_rise = dq_s && !dq_q;
  assign dq_change = dq_s != dq_q;

  // line-static timer for the sleep timeout, restarted on every change
  pmc_stable_timer #(
    .COUNT(SLEEP_CYCLES)
  ) u_line_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(dq_s),
    .clear(mode != pmc_pkg::PMC_ACTIVE),
    .stable(dq_static)
  );

  assign psw_en = {ctrl[`PMC_BIT_PIN_PSW], ctrl[`PMC_BIT_LINE_PSW]};

  // one debounce timer per power-switch input, each on its own enable
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_psw
      pmc_stable_timer #(
        .COUNT(DEBOUNCE_CYCLES)
      ) u_debounce (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .level(sync2[i]),
        .clear(!armed[i]),
        .stable(psw_stable[i])
      );
    end
  endgenerate

  // sleep entry and wake conditions
  assign sleep_block = charger_detect || charge_current_detect;
  assign bus_low_go = ctrl[`PMC_BIT_BUS_LOW] && dq_static && !dq_s;
  assign uv_go = ctrl[`PMC_BIT_LOW_CELL] && cell_below_uv && dq_static;
  assign psw_wake = |(armed & psw_stable & ~sync2);
  // own pullup would fake a rise, so line wakes are left to the power switch
  assign line_wake = !psw_en[0] && (dq_rise || (uv_sleep && dq_change));

  // mode transitions, power-switch arming and mode-driven outputs
  always_comb
  begin
    next_mode = mode;
    next_uv_sleep = uv_sleep;
    case (mode)
      pmc_pkg::PMC_ACTIVE:
      begin
        if (!sleep_block && (bus_low_go || uv_go))
        begin
          next_mode = pmc_pkg::PMC_SLEEP;
          next_uv_sleep = uv_go && !bus_low_go;
        end
      end
      pmc_pkg::PMC_SLEEP:
      begin
        if ((charger_detect && !cell_below_uv) || line_wake || psw_wake)
        begin
          next_mode = pmc_pkg::PMC_ACTIVE;
          next_uv_sleep = 1'b0;
        end
      end
      default:
      begin
        next_mode = pmc_pkg::PMC_ACTIVE;
        next_uv_sleep = 1'b0;
      end
    endcase
    // pull high while asleep, arm once the pin is seen high
    for (int i = 0; i < 2; i++)
    begin
      next_pull_oe[i] = (next_mode == pmc_pkg::PMC_SLEEP) && psw_en[i];
      next_armed[i] = (mode == pmc_pkg::PMC_SLEEP) && (next_mode == pmc_pkg::PMC_SLEEP)
        && psw_en[i] && pull_oe[i] && (armed[i] || sync2[i]);
    end
    next_mode_active = (next_mode == pmc_pkg::PMC_ACTIVE);
    next_charge = next_mode_active && protect_ok.charge;
    next_discharge = next_mode_active && protect_ok.discharge;
    next_hash_start = hash_req && (mode == pmc_pkg::PMC_ACTIVE);
    next_hash_reject = hash_req && (mode != pmc_pkg::PMC_ACTIVE);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode <= pmc_pkg::PMC_ACTIVE;
      uv_sleep <= 1'b0;
      armed <= 2'h0;
      pull_oe <= 2'h0;
      mode_active <= 1'b1;
      measure_en <= 1'b1;
      charge_fet_drive <= 1'b0;
      discharge_fet_drive <= 1'b0;
      hash_start <= 1'b0;
      hash_reject <= 1'b0;
      data_line_out <= 1'b0;
      data_line_oe <= 1'b0;
      programmable_pin_out <= 1'b0;
      programmable_pin_oe <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      uv_sleep <= next_uv_sleep;
      armed <= next_armed;
      pull_oe <= next_pull_oe;
      mode_active <= next_mode_active;
      measure_en <= next_mode_active;
      charge_fet_drive <= next_charge;
      discharge_fet_drive <= next_discharge;
      hash_start <= next_hash_start;
      hash_reject <= next_hash_reject;
      data_line_out <= next_pull_oe[0];
      data_line_oe <= next_pull_oe[0];
      programmable_pin_out <= next_pull_oe[1];
      programmable_pin_oe <= next_pull_oe[1];
    end
  end

  // control register: recall, writes, reads and save to nonvolatile copy
  always_comb
  begin
    next_ctrl = ctrl;
    if (ee_recall_valid)
      next_ctrl = ee_recall_data;
    else if (reg_req.wr && ctrl_hit(reg_req.addr))
      next_ctrl = reg_req.wdata;
    next_reg_rvalid = reg_req.rd;
    next_reg_rdata = (reg_req.rd && ctrl_hit(reg_req.addr)) ? ctrl : 8'h00;
    next_ee_save_strobe = copy_data_cmd;
    next_ee_save_data = copy_data_cmd ? ctrl : ee_save_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl <= `PMC_CTRL_RESET;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      ee_save_strobe <= 1'b0;
      ee_save_data <= 8'h00;
      neg_current_blank_en <= 1'b0;
      net_addr_opcode <= `PMC_NET_OP_SEL0;
    end
    else
    begin
      ctrl <= next_ctrl;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      ee_save_strobe <= next_ee_save_strobe;
      ee_save_data <= next_ee_save_data;
      neg_current_blank_en <= next_ctrl[`PMC_BIT_NEG_BLANK];
      net_addr_opcode <= next_ctrl[`PMC_BIT_NET_OP] ? `PMC_NET_OP_SEL1
        : `PMC_NET_OP_SEL0;
    end
  end

  // checks
  sequence s_asleep_uv_change;
    !mode_active && uv_sleep && dq_change && !psw_en[0];
  endsequence
  sequence s_charger_good_cell;
    !mode_active && charger_detect && !cell_below_uv;
  endsequence
  property p_reset_active;
    @(posedge ref_clk) !rst_n |=> mode_active && measure_en;
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("not active after reset");
  property p_fet_safe;
    @(posedge ref_clk) disable iff (!rst_n)
      charge_fet_drive |-> mode_active && $past(protect_ok.charge);
  endproperty
  a_fet_safe: assert property (p_fet_safe) else $error("charge driver unsafe");
  property p_sleep_off;
    @(posedge ref_clk) disable iff (!rst_n)
      !mode_active |-> !charge_fet_drive && !discharge_fet_drive && !measure_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("driver on in sleep");
  property p_hash_refused;
    @(posedge ref_clk) disable iff (!rst_n)
      hash_req && !mode_active |=> hash_reject && !hash_start;
  endproperty
  a_hash_refused: assert property (p_hash_refused) else $error("hash accepted in sleep");
  property p_charger_blocks;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_active && (charger_detect || charge_current_detect) |=> mode_active;
  endproperty
  a_charger_blocks: assert property (p_charger_blocks) else $error("slept while charging");
  property p_entry_cause;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(mode_active) |-> $past(dq_static) && ($past(bus_low_go) || $past(uv_go));
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("sleep without cause");
  property p_uv_disabled;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(mode_active) && !$past(ctrl[`PMC_BIT_LOW_CELL]) |-> $past(bus_low_go);
  endproperty
  a_uv_disabled: assert property (p_uv_disabled) else $error("sleep on disabled cause");
  property p_charger_wake;
    @(posedge ref_clk) disable iff (!rst_n) s_charger_good_cell |=> mode_active;
  endproperty
  a_charger_wake: assert property (p_charger_wake) else $error("no wake on charger");
  property p_uv_wake;
    @(posedge ref_clk) disable iff (!rst_n) s_asleep_uv_change |=> mode_active;
  endproperty
  a_uv_wake: assert property (p_uv_wake) else $error("no wake on line change");
  property p_pullup;
    @(posedge ref_clk) disable iff (!rst_n)
      !mode_active && $past(ctrl[`PMC_BIT_PIN_PSW])
        |-> programmable_pin_oe && programmable_pin_out;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pin not pulled in sleep");
  property p_opcode;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(ctrl[`PMC_BIT_NET_OP]) |-> net_addr_opcode == `PMC_NET_OP_SEL1;
  endproperty
  a_opcode: assert property (p_opcode) else $error("opcode not switched");

endmodule // pmc_power_mode

`default_nettype wire

// ===== tb/pmc_line_host.sv
// Purpose: host side of the data line, resolving the wire level
// Assumes: the host drives strongly, the device pull-up is weak
// Notes: a released line with no pull-up falls to the weak pulldown
`timescale 1ns/10ps
`default_nettype none

module pmc_line_host (
  input wire logic host_drive,
  input wire logic host_level,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic line
);
  // strong host beats the weak pull-up, which in turn beats the pulldown
  assign line = host_drive ? host_level : (dut_oe ? dut_out : 1'b0);
endmodule // pmc_line_host
`default_nettype wire

// ===== tb/pmc_power_mode_test.sv
// Purpose: self-checking bench of the power-mode controller
// Assumes: short sleep and debounce counts
// Notes: inputs change at the falling edge
`include "pmc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pmc_power_mode_test;
  localparam int SC = 20;
  localparam int DC = 10;
  typedef struct packed {logic [7:0] wd; logic blank; logic [7:0] op;} pmc_row_type;
  pmc_row_type rows [4] = '{'{8'h80, 1'b1, 8'h33}, '{8'h10, 1'b0, 8'h39},
                            '{8'hd7, 1'b1, 8'h39}, '{8'h00, 1'b0, 8'h33}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hd = 1'b1;
  logic hl = 1'b1;
  logic sw = 1'b0;
  logic chg = 1'b0;
  logic cur = 1'b0;
  logic uv = 1'b0;
  logic hash = 1'b0;
  logic rv = 1'b0;
  logic cpy = 1'b0;
  logic [7:0] rvd = 8'h00;
  logic [3:0] cyc = 4'h0;
  pmc_pkg::pmc_fet_type pok = 2'b11;
  pmc_pkg::pmc_reg_req_type req = '0;
  logic line, dlo, dloe, pin, plo, ploe, rvalid, save, act, meas, cfd, dfd, hs, hr, blank;
  logic [7:0] rdata, sdata, op, rd_q;
  int err_total = 0;
  int cmp_count = 0;

  // free-running count makes a floating pin toggle
  always_ff @(negedge ref_clk) cyc <= cyc + 4'h1;
  assign pin = sw ? 1'b0 : (ploe ? plo : cyc[0]);

  // clock
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  pmc_line_host i_host (.host_drive(hd), .host_level(hl), .dut_out(dlo), .dut_oe(dloe),
    .line(line));

  pmc_power_mode #(.SLEEP_CYCLES(SC), .DEBOUNCE_CYCLES(DC)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .data_line_in(line), .data_line_out(dlo),
    .data_line_oe(dloe), .programmable_pin_in(pin), .programmable_pin_out(plo),
    .programmable_pin_oe(ploe), .charger_detect(chg), .charge_current_detect(cur),
    .cell_below_uv(uv), .protect_ok(pok), .hash_req(hash), .reg_req(req),
    .ee_recall_valid(rv), .ee_recall_data(rvd), .copy_data_cmd(cpy), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .ee_save_strobe(save), .ee_save_data(sdata), .mode_active(act),
    .measure_en(meas), .charge_fet_drive(cfd), .discharge_fet_drive(dfd), .hash_start(hs),
    .hash_reject(hr), .neg_current_blank_en(blank), .net_addr_opcode(op));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = act;
      1: pick = hs;
      2: pick = hr;
      3: pick = rvalid;
      4: pick = save;
      default: pick = ~act;
    endcase
  endfunction

  // bounded wait for a flag, then insist it came
  task automatic wait_for(input int s, input int lim);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(8'(pick(s)), 8'h01);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    req.rd = 1'b0;
    wait_for(3, 4);
    rd_q = rdata;
  endtask

  // one-cycle strobe: 0 hash, 1 copy, 2 recall
  task automatic strobe(input int s);
    @(negedge ref_clk);
    hash = (s == 0);
    cpy = (s == 1);
    rv = (s == 2);
    @(negedge ref_clk);
    hash = 1'b0;
    cpy = 1'b0;
    rv = 1'b0;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    #400000;
    err_total++;
    print_verdict;
  end

  // main sequence
  initial
  begin
    idle(10);
    rst_n = 1'b1;
    idle(10);
    check(8'({act, meas}), 8'h03);
    check(op, `PMC_NET_OP_SEL0);
    check(8'({blank, dloe, ploe}), 8'h00);
    rd(`PMC_CTRL_ADDR);
    check(rd_q, `PMC_CTRL_RESET);
    pok = 2'b10;
    idle(3);
    check(8'({cfd, dfd}), 8'h02);
    pok = 2'b01;
    idle(3);
    check(8'({cfd, dfd}), 8'h01);
    pok = 2'b11;
    // register rows, bit 3 always written as zero
    for (int i = 0; i < 4; i++)
    begin
      wr(`PMC_CTRL_ADDR, rows[i].wd);
      rd(`PMC_CTRL_ADDR);
      check(rd_q, rows[i].wd);
      check(8'(blank), 8'(rows[i].blank));
      check(op, rows[i].op);
    end
    wr(8'h61, 8'hf7);
    rd(8'h61);
    check(rd_q, 8'h00);
    rd(`PMC_CTRL_ADDR);
    check(rd_q, 8'h00);
    strobe(0);
    wait_for(1, 4);
    // line low with bus-low sleep off
    hl = 1'b0;
    idle(3 * SC);
    check(8'(act), 8'h01);
    hl = 1'b1;
    // charger and charge current hold off sleep
    wr(`PMC_CTRL_ADDR, 8'h20);
    chg = 1'b1;
    hl = 1'b0;
    idle(3 * SC);
    check(8'(act), 8'h01);
    chg = 1'b0;
    cur = 1'b1;
    idle(3 * SC);
    check(8'(act), 8'h01);
    cur = 1'b0;
    wait_for(5, 3 * SC);
    check(8'({meas, cfd, dfd}), 8'h00);
    strobe(0);
    wait_for(2, 4);
    rd(`PMC_CTRL_ADDR);
    check(rd_q, 8'h20);
    hl = 1'b1;
    wait_for(0, 10);
    idle(2);
    check(8'({cfd, dfd}), 8'h03);
    // charger wake needs a good cell
    hl = 1'b0;
    wait_for(5, 3 * SC);
    uv = 1'b1;
    chg = 1'b1;
    idle(5);
    check(8'(act), 8'h00);
    uv = 1'b0;
    wait_for(0, 5);
    chg = 1'b0;
    hl = 1'b1;
    // undervoltage sleep off, then on
    wr(`PMC_CTRL_ADDR, 8'h00);
    uv = 1'b1;
    idle(3 * SC);
    check(8'(act), 8'h01);
    wr(`PMC_CTRL_ADDR, 8'h40);
    wait_for(5, 3 * SC);
    hl = 1'b0;
    wait_for(0, 10);
    uv = 1'b0;
    hl = 1'b1;
    // pin power switch: short glitch ignored, long press wakes
    wr(`PMC_CTRL_ADDR, 8'h24);
    hl = 1'b0;
    wait_for(5, 3 * SC);
    idle(4);
    check(8'({ploe, dloe}), 8'h02);
    sw = 1'b1;
    idle(DC / 2);
    sw = 1'b0;
    idle(3 * DC);
    check(8'(act), 8'h00);
    sw = 1'b1;
    wait_for(0, 3 * DC);
    sw = 1'b0;
    hl = 1'b1;
    // line power switch: own pull-up does not wake, a press does
    wr(`PMC_CTRL_ADDR, 8'h22);
    hl = 1'b0;
    wait_for(5, 3 * SC);
    hd = 1'b0;
    idle(6);
    check(8'({act, ploe, dloe}), 8'h01);
    hd = 1'b1;
    wait_for(0, 3 * DC);
    hl = 1'b1;
    // copy saves, recall loads
    strobe(1);
    wait_for(4, 4);
    check(sdata, 8'h22);
    rvd = 8'h90;
    strobe(2);
    idle(2);
    check(8'(blank), 8'h01);
    check(op, `PMC_NET_OP_SEL1);
    rd(`PMC_CTRL_ADDR);
    check(rd_q, 8'h90);
    // second reset in mid-run
    rst_n = 1'b0;
    idle(4);
    rst_n = 1'b1;
    idle(2);
    check(8'(act), 8'h01);
    rd(`PMC_CTRL_ADDR);
    check(rd_q, `PMC_CTRL_RESET);
    print_verdict;
  end
endmodule // pmc_power_mode_test
`default_nettype wire
